//--- pcm_pkg.sv
//
// How it works
// - eight two-way pins, each with a direction bit and a latch bit
// - pins two to seven are digital only; pins zero and one carry oscillator duties
// - each compare output gets its own open-drain select; the serial-peripheral outputs share one select, and the async-serial outputs share another
// - route bit set sends unit two to pin one; cleared in extended mode, to alternate
// - every reset makes all pins digital inputs
// - direction register reads back stored value, never the overridden direction
// - direction zero: compare/pwm output beats latch; one: pin feeds capture input
// - pwm channel a on pins one and two may tri-state during shutdown, else wins
// - pin zero is an external clock input only while the oscillator is off
// - don't-care functions such as oscillator input set direction, ignoring the bit
//
package pcm_pkg;
  localparam int         PCM_W         = 8;
  localparam logic [3:0] PCM_A_LEVEL   = 4'h0;
  localparam logic [3:0] PCM_A_LATCH   = 4'h1;
  localparam logic [3:0] PCM_A_DIR     = 4'h2;
  localparam logic [3:0] PCM_A_ODC1    = 4'h3;
  localparam logic [3:0] PCM_A_ODC3    = 4'h4;
  localparam logic [3:0] PCM_A_CTRL    = 4'h5;
  // open_drain_control_one fields
  localparam int         PCM_B_SPI_OD  = 7;
  localparam int         PCM_B_CU2_OD  = 6;
  localparam int         PCM_B_CU1_OD  = 5;
  // open_drain_control_three field
  localparam int         PCM_B_SER1_OD = 6;
  // control fields: pwm shutdown tri-state enables
  localparam int         PCM_B_P1_TRI  = 0;
  localparam int         PCM_B_P2_TRI  = 1;
  localparam logic [7:0] PCM_RST_DIR   = 8'hff;
  localparam logic [7:0] PCM_RST_LATCH = 8'h00;
  localparam logic [7:0] PCM_RST_ZERO  = 8'h00;
  localparam int         PCM_P_CU2     = 1;
  localparam int         PCM_P_CU1     = 2;
  localparam int         PCM_P_SCK     = 3;
  localparam int         PCM_P_SDO     = 5;
  localparam int         PCM_P_TX      = 6;
  localparam int         PCM_P_DT      = 7;

  typedef enum logic [1:0] {PCM_DRV_LATCH, PCM_DRV_PERIPH, PCM_DRV_TRI} pcm_drv_t;
endpackage

//--- pcm_mux_if.sv
`timescale 1ns/1ns
interface pcm_mux_if;
  logic [7:0] dir;
  logic [7:0] latch;
  logic [7:0] odc1;
  logic [7:0] odc3;
  logic [7:0] ctrl;
  logic       route_cu2;
  logic       ext_mode;
  logic       osc_en;
  logic       cu1_out;
  logic       cu1_en;
  logic       cu1_shut;
  logic       cu2_out;
  logic       cu2_en;
  logic       cu2_shut;
  logic       sck_out;
  logic       sck_en;
  logic       sdo_out;
  logic       sdo_en;
  logic       tx_out;
  logic       tx_en;
  logic       dt_out;
  logic       dt_en;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  logic       cu2_alt_sel;
  modport ctl (output dir, latch, odc1, odc3, ctrl, route_cu2, ext_mode, osc_en,
               output cu1_out, cu1_en, cu1_shut, cu2_out, cu2_en, cu2_shut,
               output sck_out, sck_en, sdo_out, sdo_en, tx_out, tx_en, dt_out, dt_en,
               input pin_o, pin_oe, cu2_alt_sel);
  modport mux (input dir, latch, odc1, odc3, ctrl, route_cu2, ext_mode, osc_en,
               input cu1_out, cu1_en, cu1_shut, cu2_out, cu2_en, cu2_shut,
               input sck_out, sck_en, sdo_out, sdo_en, tx_out, tx_en, dt_out, dt_en,
               output pin_o, pin_oe, cu2_alt_sel);
endinterface

//--- pcm_pin_mux.sv
`timescale 1ns/1ns
module pcm_pin_mux
  import pcm_pkg::*;
(
  pcm_mux_if.mux m
);
  // ----------------------------------------------------------------
  // per-pin drive decision
  // ----------------------------------------------------------------
  function automatic pcm_drv_t pick(input logic en, input logic shut, input logic tri_en);
    if (!en)
      return PCM_DRV_LATCH;
    else if (shut && tri_en)
      return PCM_DRV_TRI;
    else
      return PCM_DRV_PERIPH;
  endfunction

  logic     cu2_here;
  pcm_drv_t d1;
  pcm_drv_t d2;

  always_comb begin
    cu2_here      = m.route_cu2 || !m.ext_mode;
    m.cu2_alt_sel = !cu2_here;
    d1 = pick(m.cu2_en && cu2_here, m.cu2_shut, m.ctrl[PCM_B_P2_TRI]);
    d2 = pick(m.cu1_en, m.cu1_shut, m.ctrl[PCM_B_P1_TRI]);
    for (int i = 0; i < PCM_W; i++) begin
      m.pin_o[i]  = m.latch[i];
      m.pin_oe[i] = !m.dir[i];
    end
    // pin zero: oscillator output owns it and forces input
    if (m.osc_en)
      m.pin_oe[0] = 1'b0;
    // pin one: oscillator input forces direction, else compare unit two
    if (m.osc_en) begin
      m.pin_oe[1] = 1'b0;
    end else if (!m.dir[PCM_P_CU2] && d1 != PCM_DRV_LATCH) begin
      m.pin_o[1]  = m.cu2_out;
      m.pin_oe[1] = (d1 == PCM_DRV_PERIPH)
                    && !(m.odc1[PCM_B_CU2_OD] && m.cu2_out);
    end
    if (!m.dir[PCM_P_CU1] && d2 != PCM_DRV_LATCH) begin
      m.pin_o[2]  = m.cu1_out;
      m.pin_oe[2] = (d2 == PCM_DRV_PERIPH)
                    && !(m.odc1[PCM_B_CU1_OD] && m.cu1_out);
    end
    if (m.sck_en && !m.dir[PCM_P_SCK]) begin
      m.pin_o[3]  = m.sck_out;
      m.pin_oe[3] = !(m.odc1[PCM_B_SPI_OD] && m.sck_out);
    end
    if (m.sdo_en && !m.dir[PCM_P_SDO]) begin
      m.pin_o[5]  = m.sdo_out;
      m.pin_oe[5] = !(m.odc1[PCM_B_SPI_OD] && m.sdo_out);
    end
    // serial transmit outputs override the direction bit
    if (m.tx_en) begin
      m.pin_o[6]  = m.tx_out;
      m.pin_oe[6] = !(m.odc3[PCM_B_SER1_OD] && m.tx_out);
    end
    if (m.dt_en) begin
      m.pin_o[7]  = m.dt_out;
      m.pin_oe[7] = !(m.odc3[PCM_B_SER1_OD] && m.dt_out);
    end
  end
endmodule

//--- pcm_port_c.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module pcm_port_c
  import pcm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       route_cu2_cfg,
  input  wire logic       ext_mode,
  input  wire logic       osc_en,
  input  wire logic       cu1_out,
  input  wire logic       cu1_en,
  input  wire logic       cu1_shut,
  input  wire logic       cu2_out,
  input  wire logic       cu2_en,
  input  wire logic       cu2_shut,
  input  wire logic       sck_out,
  input  wire logic       sck_en,
  input  wire logic       sdo_out,
  input  wire logic       sdo_en,
  input  wire logic       tx_out,
  input  wire logic       tx_en,
  input  wire logic       dt_out,
  input  wire logic       dt_en,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe,
  output logic            cu1_capture_in,
  output logic            cu2_capture_in,
  output logic            cu2_alt_sel,
  output logic            ext_clk_in,
  output logic            sck_in,
  output logic            sdi_in,
  output logic            rx_in
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] dir_r;
  logic [7:0] latch_r;
  logic [7:0] odc1_r;
  logic [7:0] odc3_r;
  logic [7:0] ctrl_r;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] rdata_nxt;

  pcm_mux_if mif ();

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_r   <= PCM_RST_DIR;
      latch_r <= PCM_RST_LATCH;
      odc1_r  <= PCM_RST_ZERO;
      odc3_r  <= PCM_RST_ZERO;
      ctrl_r  <= PCM_RST_ZERO;
    end else if (reg_wr) begin
      case (reg_addr)
        PCM_A_LEVEL: latch_r <= reg_wdata;
        PCM_A_LATCH: latch_r <= reg_wdata;
        PCM_A_DIR:   dir_r   <= reg_wdata;
        PCM_A_ODC1:  odc1_r  <= reg_wdata;
        PCM_A_ODC3:  odc3_r  <= reg_wdata;
        PCM_A_CTRL:  ctrl_r  <= reg_wdata;
        default:     ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_r <= PCM_RST_ZERO;
      sync2_r <= PCM_RST_ZERO;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  always_comb begin
    case (reg_addr)
      PCM_A_LEVEL: rdata_nxt = sync2_r;
      PCM_A_LATCH: rdata_nxt = latch_r;
      PCM_A_DIR:   rdata_nxt = dir_r;
      PCM_A_ODC1:  rdata_nxt = odc1_r;
      PCM_A_ODC3:  rdata_nxt = odc3_r;
      PCM_A_CTRL:  rdata_nxt = ctrl_r;
      default:     rdata_nxt = PCM_RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      reg_rdata <= PCM_RST_ZERO;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= PCM_RST_ZERO;
  end

  // ----------------------------------------------------------------
  // pin multiplexer
  // ----------------------------------------------------------------
  assign mif.dir       = dir_r;
  assign mif.latch     = latch_r;
  assign mif.odc1      = odc1_r;
  assign mif.odc3      = odc3_r;
  assign mif.ctrl      = ctrl_r;
  assign mif.route_cu2 = route_cu2_cfg;
  assign mif.ext_mode  = ext_mode;
  assign mif.osc_en    = osc_en;
  assign mif.cu1_out   = cu1_out;
  assign mif.cu1_en    = cu1_en;
  assign mif.cu1_shut  = cu1_shut;
  assign mif.cu2_out   = cu2_out;
  assign mif.cu2_en    = cu2_en;
  assign mif.cu2_shut  = cu2_shut;
  assign mif.sck_out   = sck_out;
  assign mif.sck_en    = sck_en;
  assign mif.sdo_out   = sdo_out;
  assign mif.sdo_en    = sdo_en;
  assign mif.tx_out    = tx_out;
  assign mif.tx_en     = tx_en;
  assign mif.dt_out    = dt_out;
  assign mif.dt_en     = dt_en;

  pcm_pin_mux u_mux (
    .m (mif.mux)
  );

  // ----------------------------------------------------------------
  // registered pin and peripheral outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_o       <= PCM_RST_LATCH;
      pin_oe      <= PCM_RST_ZERO;
      cu2_alt_sel <= 1'b0;
    end else begin
      pin_o       <= mif.pin_o;
      pin_oe      <= mif.pin_oe;
      cu2_alt_sel <= mif.cu2_alt_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cu1_capture_in <= 1'b0;
      cu2_capture_in <= 1'b0;
      ext_clk_in     <= 1'b0;
      sck_in         <= 1'b0;
      sdi_in         <= 1'b0;
      rx_in          <= 1'b0;
    end else begin
      cu1_capture_in <= dir_r[PCM_P_CU1] & sync2_r[PCM_P_CU1];
      cu2_capture_in <= dir_r[PCM_P_CU2] & ~mif.cu2_alt_sel & sync2_r[PCM_P_CU2];
      ext_clk_in     <= ~osc_en & sync2_r[0];
      sck_in         <= sync2_r[PCM_P_SCK];
      sdi_in         <= sync2_r[4];
      rx_in          <= sync2_r[7];
    end
  end
endmodule

//--- pcm_port_c_asserts.sv
`timescale 1ns/1ns
module pcm_port_c_asserts
  import pcm_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       route_cu2_cfg,
  input wire logic       ext_mode,
  input wire logic       osc_en,
  input wire logic       cu1_out,
  input wire logic       cu1_en,
  input wire logic       cu1_shut,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic       cu2_alt_sel,
  input wire logic       ext_clk_in
);
  // ------
  // shadow copies of direction and latch
  // ------
  logic [7:0] dir_r;
  logic [7:0] lat_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dir_r <= PCM_RST_DIR;
      lat_r <= PCM_RST_LATCH;
    end else if (reg_wr) begin
      if (reg_addr == PCM_A_DIR) dir_r <= reg_wdata;
      if (reg_addr == PCM_A_LATCH || reg_addr == PCM_A_LEVEL) lat_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_alt;
    (!route_cu2_cfg && ext_mode) [*2];
  endsequence
  property p_rst_in;
    disable iff (1'b0) rst |=> pin_oe == 8'h00 && pin_o == 8'h00;
  endproperty
  property p_alt;
    s_alt |-> cu2_alt_sel;
  endproperty
  property p_dflt;
    route_cu2_cfg [*2] |-> !cu2_alt_sel;
  endproperty
  property p_osc;
    osc_en [*2] |-> pin_oe[1:0] == 2'b00;
  endproperty
  property p_xclk;
    osc_en [*6] |-> !ext_clk_in;
  endproperty
  property p_rdir;
    reg_rd && reg_addr == PCM_A_DIR |=> reg_rdata == $past(dir_r);
  endproperty
  property p_lat;
    !$past(dir_r[4]) |-> pin_oe[4] && pin_o[4] == $past(lat_r[4]);
  endproperty
  property p_cu1;
    $past(cu1_en && !dir_r[2] && !cu1_shut) |->
      (pin_oe[2] ? pin_o[2] == $past(cu1_out) : $past(cu1_out));
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("pins not inputs after reset");
  a_alt: assert property (p_alt) else $error("unit two not on alternate pin");
  a_dflt: assert property (p_dflt) else $error("unit two left default pin");
  a_osc: assert property (p_osc) else $error("oscillator pins driven");
  a_xclk: assert property (p_xclk) else $error("clock input not gated");
  a_rdir: assert property (p_rdir) else $error("direction readback wrong");
  a_lat: assert property (p_lat) else $error("latch not on pin");
  a_cu1: assert property (p_cu1) else $error("unit one output wrong");
endmodule
bind pcm_port_c pcm_port_c_asserts u_pcm_port_c_asserts (.*);

//--- pcm_board.sv
`timescale 1ns/1ns
module pcm_board (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_v,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_i
);
  // board pull-ups hold pins high that nobody drives
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_v) | (~pin_oe & ~ext_en);
endmodule

//--- pcm_port_c_test.sv
`timescale 1ns/1ns
module pcm_port_c_test;
  import pcm_pkg::*;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, ext_v = 8'h00, ext_en = 8'hff, reg_rdata, pin_o, pin_oe, pin_i;
  logic       clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, route_cu2_cfg = 1'b1;
  logic       ext_mode = 1'b0, osc_en = 1'b0, cu1_out = 1'b0, cu1_en = 1'b0, cu1_shut = 1'b0;
  logic       cu2_out = 1'b0, cu2_en = 1'b0, cu2_shut = 1'b0, sck_out = 1'b1, sck_en = 1'b0;
  logic       sdo_out = 1'b1, sdo_en = 1'b0, tx_out = 1'b1, tx_en = 1'b0, dt_out = 1'b1;
  logic       dt_en = 1'b0, cu1_capture_in, cu2_capture_in, cu2_alt_sel, ext_clk_in;
  logic       sck_in, sdi_in, rx_in;
  int         failures = 0, check_count = 0, cycles = 0;
  logic [7:0] rows [4][4] = '{'{8'h00, 8'ha5, 8'hff, 8'ha5}, '{8'hff, 8'hff, 8'h00, 8'h00},
                              '{8'hcf, 8'h3c, 8'h30, 8'h30}, '{8'h0f, 8'hf0, 8'hf0, 8'hf0}};
  pcm_port_c u_pcm_port_c (.*);
  pcm_board u_pcm_board (.*);
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
    @(posedge clk_sys);
  endtask
  // pin_o is compared only where the pin is driven
  task automatic pins(logic [7:0] m, logic [7:0] oe, logic [7:0] o, string nm);
    repeat (4) @(posedge clk_sys);
    #1 chk(nm, pin_oe & m, oe);
    chk(nm, pin_o & pin_oe & m, o);
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("oe at reset", pin_oe, 8'h00);
    @(posedge clk_sys);
    rd(PCM_A_DIR, PCM_RST_DIR, "dir at reset");
    foreach (rows[i]) begin
      wr(PCM_A_DIR, rows[i][0]);
      wr(PCM_A_LATCH, rows[i][1]);
      pins(8'hff, rows[i][2], rows[i][3], "port pins");
      rd(PCM_A_LEVEL, rows[i][3], "level");
      rd(PCM_A_DIR, rows[i][0], "dir readback");
    end
    $display("done table");
    ext_en <= 8'h00;
    wr(PCM_A_DIR, 8'h00);
    cu1_out <= 1'b1;
    cu1_en <= 1'b1;
    pins(8'h04, 8'h04, 8'h04, "unit one drive");
    wr(PCM_A_ODC1, 8'h20);
    pins(8'h04, 8'h00, 8'h00, "open drain high");
    cu1_out <= 1'b0;
    pins(8'h04, 8'h04, 8'h00, "open drain low");
    wr(PCM_A_CTRL, 8'h01);
    cu1_shut <= 1'b1;
    pins(8'h04, 8'h00, 8'h00, "shutdown tri");
    cu1_shut <= 1'b0;
    ext_en <= 8'h04;
    ext_v <= 8'h04;
    wr(PCM_A_DIR, 8'hff);
    pins(8'h04, 8'h00, 8'h00, "capture pin");
    chk("capture", {7'h00, cu1_capture_in}, 8'h01);
    $display("done unit one");
    ext_en <= 8'h00;
    wr(PCM_A_DIR, 8'h00);
    cu2_en <= 1'b1;
    cu2_out <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      route_cu2_cfg <= k[0];
      ext_mode <= k[1];
      pins(8'h02, 8'h02, {6'h00, !(!k[0] && k[1]), 1'b0}, "unit two pin");
      chk("alt select", {7'h00, cu2_alt_sel}, {7'h00, !k[0] && k[1]});
    end
    $display("done route");
    osc_en <= 1'b1;
    ext_en <= 8'h01;
    ext_v <= 8'h01;
    pins(8'h03, 8'h00, 8'h00, "osc pins");
    chk("clock gated", {7'h00, ext_clk_in}, 8'h00);
    wr(PCM_A_DIR, 8'hff);
    osc_en <= 1'b0;
    pins(8'h03, 8'h00, 8'h00, "input pins");
    chk("clock open", {7'h00, ext_clk_in}, 8'h01);
    chk("unit two capture", {7'h00, cu2_capture_in}, 8'h01);
    chk("serial inputs", {5'h00, sck_in, sdi_in, rx_in}, 8'h07);
    $display("done oscillator");
    ext_en <= 8'h00;
    wr(PCM_A_LATCH, 8'hff);
    {sck_en, sdo_en, tx_en, dt_en} <= 4'hf;
    {sck_out, sdo_out, tx_out, dt_out} <= 4'h0;
    pins(8'hf8, 8'hc0, 8'h00, "serial override");
    wr(PCM_A_DIR, 8'h00);
    pins(8'hff, 8'hff, 8'h13, "periph priority");
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00, "unmapped");
    $display("done peripherals");
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 chk("oe mid reset", pin_oe, 8'h00);
    @(posedge clk_sys);
    rd(PCM_A_DIR, PCM_RST_DIR, "dir mid reset");
    $display("done reset");
    tally_and_finish();
  end
endmodule
